// file: adc_cal_defines.vh
// Overview of operation
// - Internal conversion path carries 24-bit results and always works bipolar.
// - Zero trim and scale trim are each held as 24-bit values.
// - Reset leaves zero trim at zero and scale trim at unity.
// - Result is raw minus zero trim, times scale trim, times amplifier gain.
// - Amplifier gain comes from the two-bit gain field of configuration.
// - Unipolar mode clamps negative values to zero and doubles the result.
// - Amplifier gain and unipolar conversion are done digitally on the result.
// - Self offset calibration shorts inputs and stores raw result as zero trim.
// - Self gain calibration applies reference and stores reciprocal as scale trim.
// - System calibration uses external zero or full-scale input; trims auto-stored.
// - Zero trim is a signed two's-complement number.
// - Scale trim is unsigned 1.23 fixed point; below one half is meaningless.
// - Trim or mode changes reach the result only after the next conversion.
// - Result is 0 to 65535 unipolar, -32768 to 32767 bipolar.
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH

`define ADDR_ZERO_TRIM 3'h0
`define ADDR_SCALE_TRIM 3'h1
`define ADDR_CONFIG 3'h2
`define ADDR_CAL_CMD 3'h3
`define ADDR_STATUS 3'h4
`define ADDR_RESULT 3'h5

`define CFG_GAIN_LO 0
`define CFG_GAIN_HI 1
`define CFG_UNIPOLAR 2

`define CAL_NONE 3'h0
`define CAL_SELF_OFFSET 3'h1
`define CAL_SELF_GAIN 3'h2
`define CAL_SYS_OFFSET 3'h3
`define CAL_SYS_GAIN 3'h4

`define ZERO_TRIM_RESET 24'h000000
`define SCALE_TRIM_RESET 24'h800000
`define SCALE_FRAC_BITS 23
`define RESULT_DROP_BITS 8
`define DIV_STEPS 5'h18
`define DIV_NUMERATOR 47'h400000000000
`define DIV_MIN_DENOM 25'h0400000

`endif

// file: adc_calibration_correction.v
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "adc_cal_defines.vh"

module adc_calibration_correction (
  input wire clk,
  input wire resetn,
  input wire [23:0] raw_data,
  input wire raw_valid,
  input wire [2:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [23:0] reg_rdata,
  output reg [15:0] result,
  output reg result_valid,
  output reg input_short,
  output reg ref_to_input,
  output reg cal_busy
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DIV = 3'b100;

  reg [23:0] zero_trim_value;
  reg [23:0] scale_trim_value;
  reg [1:0] gain_sel;
  reg unipolar;
  reg [2:0] cal_mode;
  reg [2:0] state;
  reg cal_done;
  reg [46:0] div_rem;
  reg [46:0] div_den;
  reg [23:0] div_quot;
  reg [4:0] div_count;

  // Gain selection code to a left shift of 0 to 3 bits.
  function [2:0] gain_shift;
    input [1:0] code;
    begin
      gain_shift = {1'b0, code};
    end
  endfunction

  function is_gain_cal;
    input [2:0] mode;
    begin
      is_gain_cal = (mode == `CAL_SELF_GAIN) || (mode == `CAL_SYS_GAIN);
    end
  endfunction

  wire signed [24:0] diff;
  assign diff = $signed({raw_data[23], raw_data}) -
                $signed({zero_trim_value[23], zero_trim_value});

  wire signed [49:0] product;
  assign product = diff * $signed({1'b0, scale_trim_value});

  wire signed [26:0] scaled;
  assign scaled = product[49:`SCALE_FRAC_BITS];

  wire signed [31:0] widened;
  assign widened = {{5{scaled[26]}}, scaled};

  // digital amplifier gain and unipolar doubling
  wire [2:0] shift_amt;
  assign shift_amt = gain_shift(gain_sel) + {2'b00, unipolar};

  wire signed [31:0] gained;
  assign gained = widened <<< shift_amt;

  wire signed [23:0] code;
  assign code = gained[31:`RESULT_DROP_BITS];

  reg [15:0] next_result;

  always @* begin
    if (unipolar) begin
      if (code[23])
        next_result = 16'h0000;
      else if (code > $signed(24'h00ffff))
        next_result = 16'hffff;
      else
        next_result = code[15:0];
    end else begin
      if (code > $signed(24'h007fff))
        next_result = 16'h7fff;
      else if (code < $signed(24'hff8000))
        next_result = 16'h8000;
      else
        next_result = code[15:0];
    end
  end

  wire cal_cmd_wr;
  assign cal_cmd_wr = reg_wr && (reg_addr == `ADDR_CAL_CMD);

  wire cal_cmd_ok;
  assign cal_cmd_ok = (reg_wdata[2:0] != `CAL_NONE) &&
                      (reg_wdata[2:0] <= `CAL_SYS_GAIN);

  // A denominator this small would give a gain of two or more.
  wire div_saturate;
  assign div_saturate = diff <= $signed(`DIV_MIN_DENOM);

  wire [46:0] div_diff;
  assign div_diff = div_rem - div_den;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zero_trim_value <= `ZERO_TRIM_RESET;
      scale_trim_value <= `SCALE_TRIM_RESET;
      gain_sel <= 2'h0;
      unipolar <= 1'b0;
      cal_mode <= `CAL_NONE;
      state <= ST_IDLE;
      cal_done <= 1'b0;
      cal_busy <= 1'b0;
      input_short <= 1'b0;
      ref_to_input <= 1'b0;
      div_rem <= 47'h0;
      div_den <= 47'h0;
      div_quot <= 24'h0;
      div_count <= 5'h0;
      result <= 16'h0000;
      result_valid <= 1'b0;
      reg_rdata <= 24'h000000;
    end else begin
      result_valid <= 1'b0;
      reg_rdata <= 24'h000000;

      if (reg_wr) begin
        case (reg_addr)
          `ADDR_ZERO_TRIM: begin
            zero_trim_value <= reg_wdata;
          end
          `ADDR_SCALE_TRIM: begin
            scale_trim_value <= reg_wdata;
          end
          `ADDR_CONFIG: begin
            gain_sel <= reg_wdata[`CFG_GAIN_HI:`CFG_GAIN_LO];
            unipolar <= reg_wdata[`CFG_UNIPOLAR];
          end
          default: begin
          end
        endcase
      end

      if (reg_rd) begin
        case (reg_addr)
          `ADDR_ZERO_TRIM: begin
            reg_rdata <= zero_trim_value;
          end
          `ADDR_SCALE_TRIM: begin
            reg_rdata <= scale_trim_value;
          end
          `ADDR_CONFIG: begin
            reg_rdata <= {21'h0, unipolar, gain_sel};
          end
          `ADDR_CAL_CMD: begin
            reg_rdata <= {21'h0, cal_mode};
          end
          `ADDR_STATUS: begin
            reg_rdata <= {22'h0, cal_done, cal_busy};
          end
          `ADDR_RESULT: begin
            reg_rdata <= {8'h00, result};
          end
          default: begin
            reg_rdata <= 24'h000000;
          end
        endcase
      end

      case (state)
        ST_IDLE: begin
          if (cal_cmd_wr && cal_cmd_ok) begin
            cal_mode <= reg_wdata[2:0];
            cal_busy <= 1'b1;
            cal_done <= 1'b0;
            input_short <= reg_wdata[2:0] == `CAL_SELF_OFFSET;
            // reference onto input for self gain
            ref_to_input <= reg_wdata[2:0] == `CAL_SELF_GAIN;
            state <= ST_WAIT;
          end else if (raw_valid) begin
            // result moves only at a completed conversion
            result <= next_result;
            result_valid <= 1'b1;
          end
        end
        ST_WAIT: begin
          // The first conversion after the switch-over is the sample used.
          if (raw_valid) begin
            input_short <= 1'b0;
            ref_to_input <= 1'b0;
            if (!is_gain_cal(cal_mode)) begin
              zero_trim_value <= raw_data;
              cal_busy <= 1'b0;
              cal_done <= 1'b1;
              cal_mode <= `CAL_NONE;
              state <= ST_IDLE;
            end else if (div_saturate) begin
              scale_trim_value <= 24'hffffff;
              cal_busy <= 1'b0;
              cal_done <= 1'b1;
              cal_mode <= `CAL_NONE;
              state <= ST_IDLE;
            end else begin
              div_rem <= `DIV_NUMERATOR;
              div_den <= {diff[23:0], 23'h0};
              div_quot <= 24'h0;
              div_count <= `DIV_STEPS;
              state <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          // restoring division of one by the offset-free sample
          if (div_rem >= div_den) begin
            div_rem <= div_diff;
            div_quot <= {div_quot[22:0], 1'b1};
          end else begin
            div_quot <= {div_quot[22:0], 1'b0};
          end
          div_den <= {1'b0, div_den[46:1]};
          div_count <= div_count - 5'h1;
          if (div_count == 5'h1) begin
            state <= ST_IDLE;
            cal_busy <= 1'b0;
            cal_done <= 1'b1;
            cal_mode <= `CAL_NONE;
          end
        end
        default: begin
          state <= ST_IDLE;
          cal_busy <= 1'b0;
          input_short <= 1'b0;
          ref_to_input <= 1'b0;
        end
      endcase

      // gain trim stored when division ends
      if (state == ST_DIV && div_count == 5'h1) begin
        if (div_rem >= div_den)
          scale_trim_value <= {div_quot[22:0], 1'b1};
        else
          scale_trim_value <= {div_quot[22:0], 1'b0};
      end
    end
  end

endmodule

// file: adc_cal_checker_sva.sv
`timescale 1ns/1ps
`include "adc_cal_defines.vh"
module adc_cal_checker (
  input wire clk,
  input wire resetn,
  input wire raw_valid,
  input wire [2:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire [15:0] result,
  input wire result_valid,
  input wire input_short,
  input wire ref_to_input,
  input wire cal_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  conv_update_a: assert property (
    raw_valid && !cal_busy && !reg_wr |=> result_valid) else $error("no result");
  cal_hold_a: assert property (
    raw_valid && cal_busy |=> !result_valid) else $error("result during cal");
  result_hold_a: assert property (
    !result_valid |-> $stable(result)) else $error("result moved");
  short_busy_a: assert property (
    input_short |-> cal_busy) else $error("short while idle");
  ref_busy_a: assert property (
    ref_to_input |-> cal_busy) else $error("reference while idle");
  cal_start_a: assert property (
    !cal_busy && reg_wr && reg_addr == `ADDR_CAL_CMD &&
    reg_wdata == 24'h000001 |=> cal_busy && input_short) else $error("no start");
  offset_store_a: assert property (
    input_short && raw_valid |=> !cal_busy && !input_short)
    else $error("offset cal stuck");
  gain_run_a: assert property (
    ref_to_input && raw_valid |=> !ref_to_input ##0 cal_busy[*8]
    ##[1:24] !cal_busy) else $error("gain cal timing");
endmodule
bind adc_calibration_correction adc_cal_checker chk (.clk(clk),
  .resetn(resetn), .raw_valid(raw_valid), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .result(result),
  .result_valid(result_valid), .input_short(input_short),
  .ref_to_input(ref_to_input), .cal_busy(cal_busy));

// file: raw_source.sv
`timescale 1ns/1ps
module raw_source (
  input wire clk,
  input wire resetn,
  input wire [23:0] sample,
  input wire go,
  output reg [23:0] raw_data,
  output reg raw_valid
);
  // Outside a valid cycle the bus flips, so stale data cannot pass.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      raw_valid <= 1'b0;
      raw_data <= 24'h0;
    end else begin
      raw_valid <= go;
      raw_data <= go ? sample : ~raw_data;
    end
  end
endmodule

// file: adc_calibration_correction_bench.sv
`timescale 1ns/1ps
`include "adc_cal_defines.vh"
module adc_calibration_correction_bench;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, src_go = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [23:0] reg_wdata = 24'h0, src_data = 24'h0;
  wire [23:0] raw_data, reg_rdata;
  wire [15:0] result;
  wire raw_valid, result_valid, input_short, ref_to_input, cal_busy;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  logic [15:0] last = 16'h0;
  adc_calibration_correction DUT (.clk(clk), .resetn(resetn),
    .raw_data(raw_data), .raw_valid(raw_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .result(result), .result_valid(result_valid),
    .input_short(input_short), .ref_to_input(ref_to_input),
    .cal_busy(cal_busy));
  raw_source src (.clk(clk), .resetn(resetn), .sample(src_data),
    .go(src_go), .raw_data(raw_data), .raw_valid(raw_valid));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic final_report;
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [23:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic conv(input logic [23:0] v, output logic vld);
    @(posedge clk);
    src_data <= v;
    src_go <= 1'b1;
    @(posedge clk);
    src_go <= 1'b0;
    @(posedge clk);
    #1 vld = result_valid;
  endtask
  function automatic logic [15:0] ex(input logic [23:0] r, z, s,
    input logic [2:0] c);
    longint p;
    p = ((longint'($signed(r)) - longint'($signed(z))) * longint'(s)) >>> 23;
    p = p <<< c[1:0];
    if (c[2]) p = p < 0 ? 0 : p <<< 1;
    p = p >>> 8;
    if (c[2]) p = p > 65535 ? 65535 : p;
    else p = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
    return p[15:0];
  endfunction
  task automatic s_modes;
    logic [23:0] raws [3] = '{24'h010000, 24'hff0000, 24'h7fff00};
    logic v;
    rd(`ADDR_ZERO_TRIM, 24'h0);
    rd(`ADDR_SCALE_TRIM, 24'h800000);
    rd(3'h6, 24'h0);
    wr(`ADDR_ZERO_TRIM, 24'h000200);
    wr(`ADDR_SCALE_TRIM, 24'hc00000);
    rd(`ADDR_SCALE_TRIM, 24'hc00000);
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_CONFIG, 24'(c));
      rd(`ADDR_RESULT, {8'h0, last});
      for (int i = 0; i < 3; i++) begin
        conv(raws[i], v);
        last = ex(raws[i], 24'h000200, 24'hc00000, 3'(c));
        chk({7'h0, v, result}, {8'h1, last});
      end
    end
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40 && cal_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({23'h0, cal_busy}, 24'h0);
  endtask
  task automatic s_cal;
    logic v;
    wr(`ADDR_CAL_CMD, 24'h1);
    #1 chk({22'h0, input_short, cal_busy}, 24'h3);
    conv(24'h000100, v);
    chk({7'h0, v, result}, {8'h0, last});
    rd(`ADDR_ZERO_TRIM, 24'h000100);
    wr(`ADDR_CAL_CMD, 24'h2);
    #1 chk({22'h0, ref_to_input, cal_busy}, 24'h3);
    conv(24'h600100, v);
    wait_idle;
    rd(`ADDR_STATUS, 24'h000002);
    rd(`ADDR_SCALE_TRIM, 24'haaaaaa);
    wr(`ADDR_CAL_CMD, 24'h3);
    wr(`ADDR_CAL_CMD, 24'h2);
    rd(`ADDR_CAL_CMD, 24'h3);
    chk({22'h0, input_short, ref_to_input}, 24'h0);
    conv(24'hfffff0, v);
    rd(`ADDR_ZERO_TRIM, 24'hfffff0);
    wr(`ADDR_CAL_CMD, 24'h4);
    conv(24'h3ffff0, v);
    wait_idle;
    rd(`ADDR_SCALE_TRIM, 24'hffffff);
    conv(24'h001000, v);
    chk({8'h0, result}, {8'h0, ex(24'h001000, 24'hfffff0, 24'hffffff, 3'h7)});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    s_modes;
    s_cal;
    final_report;
  end
endmodule
